// ---- rtl/pxedc_pkg.sv ----
package pxedc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses on the Wishbone bus
    localparam int ADR_W = 12;
    localparam int DAT_W = 32;
    localparam int SEL_W = 4;

    localparam logic [ADR_W-1:0] OFS_ADDR_UPPER = 12'h270;
    localparam logic [ADR_W-1:0] OFS_ADDR_LOWER = 12'h274;
    localparam logic [ADR_W-1:0] OFS_ATTR_PHASE = 12'h278;
    localparam logic [ADR_W-1:0] OFS_SPLIT_MSG  = 12'h27c;
    localparam logic [ADR_W-1:0] OFS_ATTR_STAT  = 12'h280;

    localparam logic [DAT_W-1:0] RESET_WORD = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // Fields of error_attr_status
    localparam int BIT_VALID      = 31;
    localparam int BIT_OVERFLOW   = 30;
    localparam int BIT_CLEAR      = 29;
    localparam int BIT_DISCARDED  = 17;
    localparam int BIT_UNEXPECTED = 16;
    localparam int BIT_SPLIT_TO   = 15;
    localparam int BIT_ERR_MSG    = 14;
    localparam int BIT_MST_PARITY = 13;
    localparam int BIT_DET_PARITY = 12;
    localparam int BIT_RETRY      = 11;
    localparam int BIT_MST_ABORT  = 10;
    localparam int BIT_TGT_ABORT  = 9;
    localparam int BIT_DLY_TO     = 8;
    localparam int BE_LSB         = 4;
    localparam int CMD_LSB        = 0;
    localparam int BE_W           = 4;
    localparam int CMD_W          = 4;
    localparam int CLEAR_LANE     = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic             cyc;
        logic             stb;
        logic             we;
        logic [ADR_W-1:0] adr;
        logic [SEL_W-1:0] sel;
        logic [DAT_W-1:0] dat;
    } pxedc_wbreq_s;

    typedef struct packed {
        logic             strobe;
        logic             pcixMode;
        logic [63:0]      addr;
        logic [DAT_W-1:0] attrPhase;
        logic [DAT_W-1:0] splitMsg;
        logic [BE_W-1:0]  byteEn;
        logic [CMD_W-1:0] command;
        logic             discarded;
        logic             unexpected;
        logic             splitTimeout;
        logic             errMsg;
        logic             perrSeen;
        logic             wasMaster;
        logic             isWrite;
        logic             dataParity;
        logic             retryLimit;
        logic             masterAbort;
        logic             targetAbort;
        logic             delayedTimeout;
    } pxedc_err_s;

endpackage : pxedc_pkg

// ---- rtl/pxedc_capture.sv ----
// The Wishbone slave port was decided locally.
`timescale 1ns/10ps

// Functional notes
// - PCI-X error latches split completion message
// - Valid set on capture, cleared by clear
// - First error records address and attributes
// - Later error sets overflow, contents frozen
// - Overflow holds until clear written
// - Clear zeroes upper, lower, status registers; phase and split message kept
// - Clear reads zero; zero write ignored
// - Discarded completion flag, first error only
// - Unexpected completion flag, first error only
// - Split response timeout flag, first error only
// - Completion error message flag, first error
// - Master parity needs perr, master, enable
// - Parity on master read or target write
// - Retry limit flag, first error only
// - Master abort flag, first error only
// - Target abort flag, first error only
// - Delayed transaction timeout flag, first error
// - Byte enables stored in bits 7:4
// - Bus command stored in bits 3:0
// - Address halves latched into upper, lower
// - PCI-X attribute phase word latched
module pxedc_capture (
    input  wire logic                 ref_clk,
    input  wire logic                 reset,
    input  wire pxedc_pkg::pxedc_wbreq_s wbReq,
    output logic                      wbAck,
    output logic [pxedc_pkg::DAT_W-1:0] wbDatOut,
    input  wire pxedc_pkg::pxedc_err_s busErr,
    input  wire logic                 perrRespEnable,
    output logic                      captureValid,
    output logic                      captureOverflow
);
    import pxedc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Storage
    logic [DAT_W-1:0] addrUpper_q;
    logic [DAT_W-1:0] addrUpper_d;
    logic [DAT_W-1:0] addrLower_q;
    logic [DAT_W-1:0] addrLower_d;
    logic [DAT_W-1:0] attrPhase_q;
    logic [DAT_W-1:0] attrPhase_d;
    logic [DAT_W-1:0] splitMsg_q;
    logic [DAT_W-1:0] splitMsg_d;
    logic [DAT_W-1:0] attrStat_q;
    logic [DAT_W-1:0] attrStat_d;
    logic             ack_q;
    logic [DAT_W-1:0] rdData_q;

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone decode
    // Full word compare; byte addresses inside a register do not alias
    function automatic logic regHit(
        input logic [ADR_W-1:0] adr,
        input logic [ADR_W-1:0] ofs
    );
        return adr == ofs;
    endfunction : regHit

    wire logic       wbActive  = wbReq.cyc & wbReq.stb;
    wire logic       wbTaken   = wbActive & ~ack_q;
    wire logic       wbWrite   = wbActive & wbReq.we & ack_q;
    wire logic       hitUpper  = regHit(wbReq.adr, OFS_ADDR_UPPER);
    wire logic       hitLower  = regHit(wbReq.adr, OFS_ADDR_LOWER);
    wire logic       hitPhase  = regHit(wbReq.adr, OFS_ATTR_PHASE);
    wire logic       hitSplit  = regHit(wbReq.adr, OFS_SPLIT_MSG);
    wire logic       hitStat   = regHit(wbReq.adr, OFS_ATTR_STAT);

    ////////////////////////////////////////////////////////////////////////////
    // Status read view
    // Clear and reserved bits are never stored; masking them again on the
    // read path keeps any later change to the load logic from leaking them
    localparam logic [DAT_W-1:0] ONE_BIT    = 32'h0000_0001;
    localparam logic [DAT_W-1:0] LOW_FIELDS = (ONE_BIT << (BE_LSB + BE_W)) - ONE_BIT;
    localparam logic [DAT_W-1:0] STAT_READ_MASK =
        (ONE_BIT << BIT_VALID)      |
        (ONE_BIT << BIT_OVERFLOW)   |
        (ONE_BIT << BIT_DISCARDED)  |
        (ONE_BIT << BIT_UNEXPECTED) |
        (ONE_BIT << BIT_SPLIT_TO)   |
        (ONE_BIT << BIT_ERR_MSG)    |
        (ONE_BIT << BIT_MST_PARITY) |
        (ONE_BIT << BIT_DET_PARITY) |
        (ONE_BIT << BIT_RETRY)      |
        (ONE_BIT << BIT_MST_ABORT)  |
        (ONE_BIT << BIT_TGT_ABORT)  |
        (ONE_BIT << BIT_DLY_TO)     |
        LOW_FIELDS;

    wire logic [DAT_W-1:0] statRead = attrStat_q & STAT_READ_MASK;

    // Only a one in the clear lane acts; a zero write does nothing
    wire logic       clearReq  = wbWrite & hitStat & wbReq.sel[CLEAR_LANE] & wbReq.dat[BIT_CLEAR];

    wire logic [DAT_W-1:0] readWord =
        hitUpper ? addrUpper_q :
        hitLower ? addrLower_q :
        hitPhase ? attrPhase_q :
        hitSplit ? splitMsg_q  :
        hitStat  ? statRead    : RESET_WORD;

    ////////////////////////////////////////////////////////////////////////////
    // Capture decision
    // Clear acts first, so a coincident error sees an empty capture
    wire logic validEff    = attrStat_q[BIT_VALID] & ~clearReq;
    wire logic doCapture   = busErr.strobe & ~validEff;
    wire logic overflowSet = busErr.strobe & validEff;

    wire logic mstParity = busErr.perrSeen & busErr.wasMaster & perrRespEnable;
    wire logic detParity = busErr.dataParity &
                           (busErr.wasMaster ? ~busErr.isWrite : busErr.isWrite);

    ////////////////////////////////////////////////////////////////////////////
    // Field view of a fresh capture
    wire logic             freshDiscarded  = busErr.discarded;
    wire logic             freshUnexpected = busErr.unexpected;
    wire logic             freshSplitTo    = busErr.splitTimeout;
    wire logic             freshErrMsg     = busErr.errMsg;
    wire logic             freshRetry      = busErr.retryLimit;
    wire logic             freshMstAbort   = busErr.masterAbort;
    wire logic             freshTgtAbort   = busErr.targetAbort;
    wire logic             freshDlyTo      = busErr.delayedTimeout;
    wire logic [BE_W-1:0]  freshByteEn     = busErr.byteEn;
    wire logic [CMD_W-1:0] freshCommand    = busErr.command;

    // Valid is always set: only a capture ever loads this word
    function automatic logic [DAT_W-1:0] statusWord(
        input logic             discarded,
        input logic             unexpected,
        input logic             splitTo,
        input logic             errMsg,
        input logic             mp,
        input logic             dp,
        input logic             retry,
        input logic             mstAbort,
        input logic             tgtAbort,
        input logic             dlyTo,
        input logic [BE_W-1:0]  byteEn,
        input logic [CMD_W-1:0] command
    );
        logic [DAT_W-1:0] w;
        w = RESET_WORD;
        w[BIT_VALID]        = 1'b1;
        w[BIT_DISCARDED]    = discarded;
        w[BIT_UNEXPECTED]   = unexpected;
        w[BIT_SPLIT_TO]     = splitTo;
        w[BIT_ERR_MSG]      = errMsg;
        w[BIT_MST_PARITY]   = mp;
        w[BIT_DET_PARITY]   = dp;
        w[BIT_RETRY]        = retry;
        w[BIT_MST_ABORT]    = mstAbort;
        w[BIT_TGT_ABORT]    = tgtAbort;
        w[BIT_DLY_TO]       = dlyTo;
        w[BE_LSB +: BE_W]   = byteEn;
        w[CMD_LSB +: CMD_W] = command;
        return w;
    endfunction : statusWord

    wire logic [DAT_W-1:0] freshStatus = statusWord(
        freshDiscarded,
        freshUnexpected,
        freshSplitTo,
        freshErrMsg,
        mstParity,
        detParity,
        freshRetry,
        freshMstAbort,
        freshTgtAbort,
        freshDlyTo,
        freshByteEn,
        freshCommand
    );

    // Overflow on a frozen capture; clear bit itself is never stored
    function automatic logic [DAT_W-1:0] withOverflow(input logic [DAT_W-1:0] w);
        logic [DAT_W-1:0] r;
        r = w;
        r[BIT_OVERFLOW] = 1'b1;
        return r;
    endfunction : withOverflow

    ////////////////////////////////////////////////////////////////////////////
    // Next values
    assign addrUpper_d = doCapture ? busErr.addr[63:32] :
                         clearReq  ? RESET_WORD : addrUpper_q;
    assign addrLower_d = doCapture ? busErr.addr[31:0] :
                         clearReq  ? RESET_WORD : addrLower_q;
    // Conventional PCI has no attribute phase or split message: load zero
    assign attrPhase_d = doCapture ? (busErr.pcixMode ? busErr.attrPhase : RESET_WORD) : attrPhase_q;
    assign splitMsg_d  = doCapture ? (busErr.pcixMode ? busErr.splitMsg : RESET_WORD) : splitMsg_q;
    assign attrStat_d  = doCapture   ? freshStatus :
                         clearReq    ? RESET_WORD :
                         overflowSet ? withOverflow(attrStat_q) :
                                       attrStat_q;

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    // One block per register keeps each load path short
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            addrUpper_q <= RESET_WORD;
        end else begin
            addrUpper_q <= addrUpper_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            addrLower_q <= RESET_WORD;
        end else begin
            addrLower_q <= addrLower_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            attrPhase_q <= RESET_WORD;
        end else begin
            attrPhase_q <= attrPhase_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            splitMsg_q <= RESET_WORD;
        end else begin
            splitMsg_q <= splitMsg_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            attrStat_q <= RESET_WORD;
        end else begin
            attrStat_q <= attrStat_d;
        end
    end

    // One wait state; ack drops the cycle after it is given
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= wbTaken;
        end
    end

    // Taken on first sight of the request, so it stands while ack is high
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rdData_q <= RESET_WORD;
        end else begin
            rdData_q <= wbTaken ? readWord : rdData_q;
        end
    end

    assign wbAck           = ack_q & wbActive;
    assign wbDatOut        = rdData_q;
    assign captureValid    = attrStat_q[BIT_VALID];
    assign captureOverflow = attrStat_q[BIT_OVERFLOW];

endmodule : pxedc_capture

// ---- tb/pxedc_err_source.sv ----
`timescale 1ns/10ps
module pxedc_err_source (
    input  wire logic            ref_clk,
    output pxedc_pkg::pxedc_err_s busErr
);
    import pxedc_pkg::*;
    initial busErr = '0;
    // Stale fields show the inverse so a late sample cannot match
    task fire(input pxedc_err_s e);
        @(posedge ref_clk);
        busErr <= e;
        @(posedge ref_clk);
        busErr <= {1'b0, ~e[$bits(pxedc_err_s)-2:0]};
    endtask : fire
endmodule : pxedc_err_source

// ---- tb/pxedc_capture_assertions.sv ----
`timescale 1ns/10ps
module pxedc_capture_assertions (
    input wire logic                    ref_clk,
    input wire logic                    reset,
    input wire pxedc_pkg::pxedc_wbreq_s wbReq,
    input wire logic                    wbAck,
    input wire logic [pxedc_pkg::DAT_W-1:0] wbDatOut,
    input wire pxedc_pkg::pxedc_err_s   busErr,
    input wire logic                    perrRespEnable,
    input wire logic                    captureValid,
    input wire logic                    captureOverflow
);
    import pxedc_pkg::*;
    wire stat = wbAck && wbReq.adr == OFS_ATTR_STAT;
    wire clr  = stat && wbReq.we && wbReq.sel[CLEAR_LANE] && wbReq.dat[BIT_CLEAR];
    wire err  = busErr.strobe;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    property p_valid_set; err |=> captureValid; endproperty
    a_valid_set: assert property (p_valid_set) else $error("valid not set");
    property p_valid_clr; clr && !err |=> !captureValid; endproperty
    a_valid_clr: assert property (p_valid_clr) else $error("valid not cleared");
    property p_valid_hold; captureValid && !clr |=> captureValid; endproperty
    a_valid_hold: assert property (p_valid_hold) else $error("valid lost");
    property p_ovf_set; err && captureValid && !clr |=> captureOverflow; endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow not set");
    property p_ovf_hold; captureOverflow && !clr |=> captureOverflow; endproperty
    a_ovf_hold: assert property (p_ovf_hold) else $error("overflow lost");
    property p_ovf_clr; clr |=> !captureOverflow; endproperty
    a_ovf_clr: assert property (p_ovf_clr) else $error("overflow not cleared");
    property p_clr_rd0; stat && !wbReq.we |-> !wbDatOut[BIT_CLEAR]; endproperty
    a_clr_rd0: assert property (p_clr_rd0) else $error("clear bit reads one");
    property p_rearm; clr && err |=> captureValid && !captureOverflow; endproperty
    a_rearm: assert property (p_rearm) else $error("no fresh capture");
endmodule : pxedc_capture_assertions
bind pxedc_capture pxedc_capture_assertions u_chk (.ref_clk(ref_clk), .reset(reset),
    .wbReq(wbReq), .wbAck(wbAck), .wbDatOut(wbDatOut), .busErr(busErr),
    .perrRespEnable(perrRespEnable), .captureValid(captureValid), .captureOverflow(captureOverflow));

// ---- tb/pxedc_capture_tb.sv ----
`timescale 1ns/10ps
module pxedc_capture_tb;
    import pxedc_pkg::*;
    localparam pxedc_err_s E1 = {2'h3, 64'h0123456789abcdef, 32'h11112222, 32'h33334444, 8'ha7, 12'h9dd};
    localparam pxedc_err_s E2 = {2'h3, 64'h0, 32'hffffffff, 32'hffffffff, 8'hff, 12'hfff};
    localparam pxedc_err_s E3 = {2'h2, 64'hfedcba9876543210, 32'h55556666, 32'h77778888, 8'h53, 12'h6b2};
    localparam pxedc_err_s E4 = {2'h3, 64'haaaabbbbccccdddd, 32'h9, 32'h8, 8'hfc, 12'h004};
    logic             ref_clk = 1'b0;
    logic             reset = 1'b1;
    logic             perrRespEnable = 1'b1;
    pxedc_wbreq_s     wbReq = '0;
    logic             wbAck;
    logic             captureValid;
    logic             captureOverflow;
    logic [DAT_W-1:0] wbDatOut;
    logic [DAT_W-1:0] v;
    pxedc_err_s       busErr;
    int               errCount = 0;
    int               checks = 0;
    int               cycles = 0;
    pxedc_capture dut (.ref_clk(ref_clk), .reset(reset), .wbReq(wbReq), .wbAck(wbAck),
        .wbDatOut(wbDatOut), .busErr(busErr), .perrRespEnable(perrRespEnable),
        .captureValid(captureValid), .captureOverflow(captureOverflow));
    pxedc_err_source src (.ref_clk(ref_clk), .busErr(busErr));
    initial forever #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            errCount++;
            report_and_stop();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task report_and_stop;
        $display("errors %0d checks %0d", errCount, checks);
        if (errCount == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errCount++;
            $display("BAD %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check
    task wb(input logic we, input logic [ADR_W-1:0] adr, input logic [31:0] dat, output logic [31:0] rd);
        @(posedge ref_clk);
        wbReq <= '{1'b1, 1'b1, we, adr, 4'hf, dat};
        do @(posedge ref_clk); while (wbAck !== 1'b1);
        rd = wbDatOut;
        wbReq <= '0;
    endtask : wb
    task rc(input logic [ADR_W-1:0] adr, input logic [31:0] exp);
        logic [31:0] r;
        wb(1'b0, adr, 32'h0, r);
        check(r, exp);
    endtask : rc
    task regs(input logic [31:0] u, input logic [31:0] l, input logic [31:0] a, input logic [31:0] s,
              input logic [31:0] t);
        rc(OFS_ADDR_UPPER, u);
        rc(OFS_ADDR_LOWER, l);
        rc(OFS_ATTR_PHASE, a);
        rc(OFS_SPLIT_MSG, s);
        rc(OFS_ATTR_STAT, t);
    endtask : regs
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        regs('0, '0, '0, '0, '0);
        rc(12'h000, 32'h0);
        src.fire(E1);
        wb(1'b1, OFS_SPLIT_MSG, 32'hdeadbeef, v);
        regs(32'h01234567, 32'h89abcdef, 32'h11112222, 32'h33334444, 32'h80027da7);
        src.fire(E2);
        regs(32'h01234567, 32'h89abcdef, 32'h11112222, 32'h33334444, 32'hc0027da7);
        check({30'h0, captureValid, captureOverflow}, 32'h3);
        wb(1'b1, OFS_ATTR_STAT, 32'h0, v);
        rc(OFS_ATTR_STAT, 32'hc0027da7);
        wb(1'b1, OFS_ATTR_STAT, 32'h20000000, v);
        regs('0, '0, 32'h11112222, 32'h33334444, '0);
        check({30'h0, captureValid, captureOverflow}, 32'h0);
        src.fire(E3);
        regs(32'hfedcba98, 32'h76543210, '0, '0, 32'h80019253);
        fork
            wb(1'b1, OFS_ATTR_STAT, 32'h20000000, v);
            begin
                @(posedge ref_clk);
                src.fire(E4);
            end
        join
        regs(32'haaaabbbb, 32'hccccdddd, 32'h9, 32'h8, 32'h800004fc);
        wb(1'b1, OFS_ATTR_STAT, 32'h20000000, v);
        perrRespEnable <= 1'b0;
        src.fire(E1);
        rc(OFS_ATTR_STAT, 32'h80025da7);
        report_and_stop();
    end
endmodule : pxedc_capture_tb
